// >>> verilog/loop_cfg_pkg.sv
// register map, field layout and decode constants for the loop configuration bank
package loop_cfg_pkg;
  localparam int addr_w = 8;
  localparam int data_w = 8;
  localparam logic [7:0] timing_lock_setup_addr = 8'h11;
  localparam logic [7:0] freq_detector_control_addr = 8'h12;
  localparam logic [7:0] carrier_alpha_noise_control_addr = 8'h13;
  localparam logic [7:0] carrier_beta_phase_select_addr = 8'h14;
  localparam logic [7:0] carrier_lock_threshold_addr = 8'h15;
  localparam logic [7:0] gain_loop_integrator_addr = 8'h16;
  localparam logic [7:0] timing_lock_indicator_addr = 8'h17;
  localparam logic [7:0] timing_lock_setup_rst = 8'h88;
  localparam logic [7:0] freq_detector_control_rst = 8'hf7;
  localparam logic [7:0] carrier_alpha_noise_control_rst = 8'h88;
  localparam logic [7:0] carrier_beta_phase_select_rst = 8'h5c;
  localparam logic [7:0] carrier_lock_threshold_rst = 8'h14;
  // freq_detector_control fields
  localparam int fd_couple_bit = 7;
  localparam int fd_gain_hi = 6;
  localparam int fd_gain_lo = 4;
  localparam int fd_mode_hi = 3;
  localparam int fd_mode_lo = 2;
  localparam int fd_thr_hi = 1;
  localparam int fd_thr_lo = 0;
  // carrier_alpha_noise_control fields
  localparam int derot_bit = 7;
  localparam int noise_hi = 5;
  localparam int noise_lo = 4;
  localparam int alpha_b_hi = 3;
  localparam int alpha_b_lo = 1;
  localparam int alpha_a_bit = 0;
  // carrier_beta_phase_select fields
  localparam int algo_hi = 7;
  localparam int algo_lo = 6;
  localparam int beta_e_hi = 5;
  localparam int beta_e_lo = 2;
  localparam int beta_c_bit = 1;
  localparam int beta_d_bit = 0;
  // detector disable thresholds per code
  localparam logic signed [7:0] fd_thr_code0 = -8'sd16;
  localparam logic signed [7:0] fd_thr_code1 = -8'sd32;
  localparam logic signed [7:0] fd_thr_code2 = -8'sd48;
  localparam logic signed [7:0] fd_thr_code3 = -8'sd64;
  // noise averaging length in symbols, one k taken as 1024
  localparam int noise_len_w = 19;
  localparam logic [18:0] noise_len_code0 = 19'h01000;
  localparam logic [18:0] noise_len_code1 = 19'h04000;
  localparam logic [18:0] noise_len_code2 = 19'h10000;
  localparam logic [18:0] noise_len_code3 = 19'h40000;
  typedef enum logic [1:0] {algo_bpsk, algo_qpsk_1, algo_qpsk_2, algo_reserved} phase_algo_t;
endpackage

// >>> verilog/loop_cfg_if.sv
// raw register fields passed from the register bank to the field decoder
interface loop_cfg_if;
  logic [1:0] fd_thr_code;
  logic [1:0] noise_code;
  logic [1:0] algo_code;
  logic signed [7:0] lock_value;
  logic signed [7:0] fd_threshold;
  logic [18:0] noise_len;
  loop_cfg_pkg::phase_algo_t algo;
  logic algo_valid;
  logic fd_reached;
  modport bank (output fd_thr_code, output noise_code, output algo_code, output lock_value,
                input fd_threshold, input noise_len, input algo, input algo_valid,
                input fd_reached);
  modport dec (input fd_thr_code, input noise_code, input algo_code, input lock_value,
               output fd_threshold, output noise_len, output algo, output algo_valid,
               output fd_reached);
endinterface

// >>> verilog/loop_field_decode.sv
// combinational decode of threshold, averaging length and phase detector codes
module loop_field_decode (
  loop_cfg_if.dec cfg
);
  always_comb begin
    case (cfg.fd_thr_code)
      2'h0: cfg.fd_threshold = loop_cfg_pkg::fd_thr_code0;
      2'h1: cfg.fd_threshold = loop_cfg_pkg::fd_thr_code1;
      2'h2: cfg.fd_threshold = loop_cfg_pkg::fd_thr_code2;
      default: cfg.fd_threshold = loop_cfg_pkg::fd_thr_code3;
    endcase
  end

  // lock value falls as lock improves, so reaching means at or below
  always_comb begin
    cfg.fd_reached = (cfg.lock_value <= cfg.fd_threshold);
  end

  always_comb begin
    case (cfg.noise_code)
      2'h0: cfg.noise_len = loop_cfg_pkg::noise_len_code0;
      2'h1: cfg.noise_len = loop_cfg_pkg::noise_len_code1;
      2'h2: cfg.noise_len = loop_cfg_pkg::noise_len_code2;
      default: cfg.noise_len = loop_cfg_pkg::noise_len_code3;
    endcase
  end

  always_comb begin
    cfg.algo = loop_cfg_pkg::phase_algo_t'(cfg.algo_code);
    case (cfg.algo_code)
      2'h3: cfg.algo_valid = 1'b0;
      default: cfg.algo_valid = 1'b1;
    endcase
  end
endmodule

// >>> verilog/carrier_timing_loop_config_regs.sv
// configuration and status registers for the timing and carrier recovery loops
// Contract
// - bit 7 couples frequency detector
// - bits 6:4 give detector gain coefficient
// - detector disabled at selected lock threshold
// - noise averaging 4k to 256k symbols
// - alpha field splits into b and a
// - bits 7:6 select phase detector algorithm
// - lock threshold compared as signed number
// - gain integrator readable as signed byte
module carrier_timing_loop_config_regs (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // host register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  // status from the loops
  input wire logic signed [7:0] agc1_integrator,
  input wire logic [7:0] timing_lock_quality,
  input wire logic signed [7:0] carrier_lock_value,
  // loop controls
  output logic [7:0] timing_lock_setup_value,
  output logic fd_coupled,
  output logic [2:0] fd_gain,
  output logic [1:0] fd_mode_bits,
  output logic signed [7:0] fd_threshold,
  output logic derotator_on,
  output logic [18:0] noise_avg_len,
  output logic [2:0] alpha_car_b,
  output logic alpha_car_a,
  output loop_cfg_pkg::phase_algo_t phase_algo,
  output logic phase_algo_valid,
  output logic [3:0] beta_car_e,
  output logic beta_car_c,
  output logic beta_car_d,
  output logic carrier_locked
);
  logic [7:0] timing_lock_setup;
  logic [7:0] freq_detector_control;
  logic [7:0] carrier_alpha_noise_control;
  logic [7:0] carrier_beta_phase_select;
  logic [7:0] carrier_lock_threshold;
  logic [7:0] next_rdata;

  // one address decode shared by the write paths and the read mux
  typedef enum logic [2:0] {
    sel_setup,
    sel_fd,
    sel_alpha,
    sel_beta,
    sel_lock_thr,
    sel_integrator,
    sel_indicator,
    sel_none
  } reg_sel_t;

  function automatic reg_sel_t decode_addr(logic [7:0] a);
    case (a)
      loop_cfg_pkg::timing_lock_setup_addr: decode_addr = sel_setup;
      loop_cfg_pkg::freq_detector_control_addr: decode_addr = sel_fd;
      loop_cfg_pkg::carrier_alpha_noise_control_addr: decode_addr = sel_alpha;
      loop_cfg_pkg::carrier_beta_phase_select_addr: decode_addr = sel_beta;
      loop_cfg_pkg::carrier_lock_threshold_addr: decode_addr = sel_lock_thr;
      loop_cfg_pkg::gain_loop_integrator_addr: decode_addr = sel_integrator;
      loop_cfg_pkg::timing_lock_indicator_addr: decode_addr = sel_indicator;
      default: decode_addr = sel_none;
    endcase
  endfunction

  reg_sel_t sel;

  assign sel = decode_addr(reg_addr);

  loop_cfg_if cfg ();

  assign cfg.fd_thr_code =
    freq_detector_control[loop_cfg_pkg::fd_thr_hi:loop_cfg_pkg::fd_thr_lo];
  assign cfg.noise_code =
    carrier_alpha_noise_control[loop_cfg_pkg::noise_hi:loop_cfg_pkg::noise_lo];
  assign cfg.algo_code =
    carrier_beta_phase_select[loop_cfg_pkg::algo_hi:loop_cfg_pkg::algo_lo];
  assign cfg.lock_value = carrier_lock_value;

  loop_field_decode u_decode (
    .cfg(cfg.dec)
  );

  // software may write any value; recommended contents are its duty
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      timing_lock_setup <= loop_cfg_pkg::timing_lock_setup_rst;
    end else if (reg_wr && sel == sel_setup) begin
      timing_lock_setup <= reg_wdata;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      freq_detector_control <= loop_cfg_pkg::freq_detector_control_rst;
    end else if (reg_wr && sel == sel_fd) begin
      freq_detector_control <= reg_wdata;
    end
  end

  // bit 6 is kept as written but drives nothing
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      carrier_alpha_noise_control <= loop_cfg_pkg::carrier_alpha_noise_control_rst;
    end else if (reg_wr && sel == sel_alpha) begin
      carrier_alpha_noise_control <= reg_wdata;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      carrier_beta_phase_select <= loop_cfg_pkg::carrier_beta_phase_select_rst;
    end else if (reg_wr && sel == sel_beta) begin
      carrier_beta_phase_select <= reg_wdata;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      carrier_lock_threshold <= loop_cfg_pkg::carrier_lock_threshold_rst;
    end else if (reg_wr && sel == sel_lock_thr) begin
      carrier_lock_threshold <= reg_wdata;
    end
  end

  // read mux; read-only and unmapped writes are dropped, unmapped reads give zero
  always_comb begin
    case (sel)
      sel_setup: next_rdata = timing_lock_setup;
      sel_fd: next_rdata = freq_detector_control;
      sel_alpha: next_rdata = carrier_alpha_noise_control;
      sel_beta: next_rdata = carrier_beta_phase_select;
      sel_lock_thr: next_rdata = carrier_lock_threshold;
      sel_integrator: next_rdata = agc1_integrator;
      sel_indicator: next_rdata = timing_lock_quality;
      default: next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      reg_rdata <= 8'h00;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= next_rdata;
      end
    end
  end

  // frequency detector controls, one cycle behind the register
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      fd_coupled <= 1'b0;
      fd_gain <= 3'h0;
      fd_mode_bits <= 2'h0;
      fd_threshold <= 8'sh00;
    end else begin
      fd_coupled <= freq_detector_control[loop_cfg_pkg::fd_couple_bit]
                    && !cfg.fd_reached;
      fd_gain <=
        freq_detector_control[loop_cfg_pkg::fd_gain_hi:loop_cfg_pkg::fd_gain_lo];
      fd_mode_bits <= freq_detector_control[loop_cfg_pkg::fd_mode_hi:loop_cfg_pkg::fd_mode_lo];
      fd_threshold <= cfg.fd_threshold;
    end
  end

  // carrier alpha, derotator and noise estimator controls
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      derotator_on <= 1'b0;
      noise_avg_len <= 19'h00000;
      alpha_car_b <= 3'h0;
      alpha_car_a <= 1'b0;
    end else begin
      derotator_on <= carrier_alpha_noise_control[loop_cfg_pkg::derot_bit];
      noise_avg_len <= cfg.noise_len;
      alpha_car_b <=
        carrier_alpha_noise_control[loop_cfg_pkg::alpha_b_hi:loop_cfg_pkg::alpha_b_lo];
      alpha_car_a <= carrier_alpha_noise_control[loop_cfg_pkg::alpha_a_bit];
    end
  end

  // phase detector and beta fields; reserved algorithm passed on but flagged
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      phase_algo <= loop_cfg_pkg::algo_bpsk;
      phase_algo_valid <= 1'b0;
      beta_car_e <= 4'h0;
      beta_car_c <= 1'b0;
      beta_car_d <= 1'b0;
    end else begin
      phase_algo <= cfg.algo;
      phase_algo_valid <= cfg.algo_valid;
      beta_car_e <=
        carrier_beta_phase_select[loop_cfg_pkg::beta_e_hi:loop_cfg_pkg::beta_e_lo];
      beta_car_c <= carrier_beta_phase_select[loop_cfg_pkg::beta_c_bit];
      beta_car_d <= carrier_beta_phase_select[loop_cfg_pkg::beta_d_bit];
    end
  end

  // lock judged on signed compare; lock value falls as lock improves
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      carrier_locked <= 1'b0;
    end else begin
      carrier_locked <= (carrier_lock_value <= $signed(carrier_lock_threshold));
    end
  end

  // setup copy for the timing loop, registered so the pin never glitches
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      timing_lock_setup_value <= 8'h00;
    end else begin
      timing_lock_setup_value <= timing_lock_setup;
    end
  end
endmodule

// >>> tb/carrier_timing_loop_config_regs_checker.sv
// assertions on the loop configuration register bank ports
module carrier_timing_loop_config_regs_checker (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // host port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic reg_rvalid,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  // loop side
  input wire logic [7:0] timing_lock_quality,
  input wire logic signed [7:0] agc1_integrator,
  input wire logic signed [7:0] carrier_lock_value,
  input wire logic signed [7:0] fd_threshold,
  input wire logic fd_coupled,
  input wire logic derotator_on,
  input wire logic phase_algo_valid,
  input wire logic carrier_locked,
  input wire logic [2:0] fd_gain,
  input wire logic [18:0] noise_avg_len
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // write left alone one cycle, so the decode two edges on is its own
  sequence wr_alone(a);
    reg_wr && reg_addr == a ##1 !(reg_wr && reg_addr == a);
  endsequence
  rvalid_pulse_a:
    assert property (1 |=> reg_rvalid == $past(reg_rd)) else $error("rvalid timing");
  agc_read_a:
    assert property (reg_rd && reg_addr == 8'h16 |=> reg_rdata == $past(agc1_integrator))
      else $error("integrator readback");
  lock_ind_read_a:
    assert property (reg_rd && reg_addr == 8'h17 |=> reg_rdata == $past(timing_lock_quality))
      else $error("lock indicator readback");
  fd_gain_a:
    assert property (wr_alone(8'h12) |=> fd_gain == $past(reg_wdata[6:4], 2))
      else $error("fd gain");
  fd_thr_a:
    assert property (wr_alone(8'h12) |=>
      fd_threshold == -8'sd16 * ($past(reg_wdata[1:0], 2) + 8'sd1))
      else $error("fd threshold");
  fd_release_a:
    assert property (fd_coupled |-> $past(carrier_lock_value) > fd_threshold) else $error("fd kept");
  fd_off_a:
    assert property (wr_alone(8'h12) ##1 !$past(reg_wdata[7], 2) |-> !fd_coupled)
      else $error("fd on");
  noise_len_a:
    assert property (wr_alone(8'h13) |=> noise_avg_len == 19'h01000 << 2 * $past(reg_wdata[5:4], 2)
      && derotator_on == $past(reg_wdata[7], 2)) else $error("noise or derotator");
  algo_valid_a:
    assert property (wr_alone(8'h14) |=> phase_algo_valid == ($past(reg_wdata[7:6], 2) != 2'h3))
      else $error("algo valid");
  lock_cmp_a:
    assert property (wr_alone(8'h15) |=> carrier_locked ==
      ($past(carrier_lock_value) <= $signed($past(reg_wdata, 2)))) else $error("carrier lock");
endmodule
bind carrier_timing_loop_config_regs carrier_timing_loop_config_regs_checker chk_u (
  .ref_clk(ref_clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rvalid(reg_rvalid),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .timing_lock_quality(timing_lock_quality), .agc1_integrator(agc1_integrator),
  .carrier_lock_value(carrier_lock_value), .fd_threshold(fd_threshold),
  .fd_coupled(fd_coupled), .derotator_on(derotator_on), .phase_algo_valid(phase_algo_valid),
  .carrier_locked(carrier_locked), .fd_gain(fd_gain), .noise_avg_len(noise_avg_len)
);

// >>> tb/carrier_timing_loop_config_regs_tb.sv
// self-checking bench for the loop configuration register bank
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin err_total++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, s); end end
module carrier_timing_loop_config_regs_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 0, rst = 1, reg_wr = 0, reg_rd = 0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, timing_lock_quality = 8'hd3;
  logic signed [7:0] agc1_integrator = 8'h9c, carrier_lock_value = 8'h00, fd_threshold;
  logic reg_rvalid, fd_coupled, derotator_on, alpha_car_a, phase_algo_valid;
  logic beta_car_c, beta_car_d, carrier_locked;
  logic [7:0] timing_lock_setup_value;
  logic [2:0] fd_gain, alpha_car_b;
  logic [1:0] fd_mode_bits;
  logic [18:0] noise_avg_len;
  logic [3:0] beta_car_e;
  loop_cfg_pkg::phase_algo_t phase_algo;
  int err_total = 0;
  int checks_done = 0;
  always #20 ref_clk = ~ref_clk;
  carrier_timing_loop_config_regs dut_u (
    .ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .agc1_integrator(agc1_integrator), .timing_lock_quality(timing_lock_quality),
    .carrier_lock_value(carrier_lock_value), .timing_lock_setup_value(timing_lock_setup_value),
    .fd_coupled(fd_coupled), .fd_gain(fd_gain), .fd_mode_bits(fd_mode_bits),
    .fd_threshold(fd_threshold), .derotator_on(derotator_on), .noise_avg_len(noise_avg_len),
    .alpha_car_b(alpha_car_b), .alpha_car_a(alpha_car_a), .phase_algo(phase_algo),
    .phase_algo_valid(phase_algo_valid), .beta_car_e(beta_car_e), .beta_car_c(beta_car_c),
    .beta_car_d(beta_car_d), .carrier_locked(carrier_locked)
  );
  task automatic finish_test();
    if (err_total == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic tick(int n);
    repeat (n) @(negedge ref_clk);
  endtask
  // an idle cycle after each access keeps strobes from being set twice in one step
  task automatic wr(logic [7:0] a, logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1;
    tick(1);
    reg_wr = 0;
    tick(1);
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] e);
    int i;
    reg_addr = a;
    reg_rd = 1;
    tick(1);
    reg_rd = 0;
    for (i = 0; i < 4 && reg_rvalid !== 1'b1; i++) tick(1);
    if (i == 4) begin
      err_total++;
      finish_test();
    end
    `CHK("read data", e, reg_rdata)
    tick(1);
  endtask
  initial begin
    static logic [7:0] rst_val [5] = '{8'h88, 8'hf7, 8'h88, 8'h5c, 8'h14};
    static logic [7:0] lv [4] = '{8'hf0, 8'hf1, 8'h7f, 8'h80};
    static logic [3:0] lk = 4'h9;
    tick(6);
    rst = 0;
    tick(2);
    `CHK("fd_gain", 3'h7, fd_gain)
    `CHK("fd_threshold", 8'hc0, fd_threshold)
    `CHK("noise_avg_len", 19'h01000, noise_avg_len)
    `CHK("phase_algo", loop_cfg_pkg::algo_qpsk_1, phase_algo)
    `CHK("phase_algo_valid", 1'b1, phase_algo_valid)
    `CHK("derotator_on", 1'b1, derotator_on)
    // lock value zero sits above -64, so the detector stays coupled
    `CHK("fd_coupled", 1'b1, fd_coupled)
    `CHK("fd_mode_bits", 2'h1, fd_mode_bits)
    for (int i = 0; i < 5; i++) rd(8'(8'h11 + i), rst_val[i]);
    rd(8'h16, 8'h9c);
    wr(8'h17, 8'h00);
    rd(8'h17, 8'hd3);
    rd(8'h30, 8'h00);
    wr(8'h11, 8'h84);
    `CHK("setup", 8'h84, timing_lock_setup_value)
    for (int c = 0; c < 4; c++) begin
      wr(8'h12, 8'hd8 | 8'(c));
      `CHK("fd_gain", 3'h5, fd_gain)
      `CHK("fd_threshold", 8'(-16 * (c + 1)), fd_threshold)
      `CHK("fd_mode_bits", 2'h2, fd_mode_bits)
      // exactly at the threshold counts as reached
      carrier_lock_value = 8'(-16 * (c + 1));
      tick(1);
      `CHK("fd_coupled", 1'b0, fd_coupled)
      carrier_lock_value = 8'(-15 - 16 * c);
      tick(1);
      `CHK("fd_coupled", 1'b1, fd_coupled)
    end
    wr(8'h12, 8'h5a);
    carrier_lock_value = 8'h7f;
    tick(1);
    `CHK("fd_coupled", 1'b0, fd_coupled)
    for (int c = 0; c < 4; c++) begin
      wr(8'h13, {c[0], 1'b0, 2'(c), 4'hb});
      `CHK("noise_avg_len", 19'h01000 << (2 * c), noise_avg_len)
      `CHK("derotator_on", c[0], derotator_on)
      `CHK("alpha_car", 4'hb, {alpha_car_b, alpha_car_a})
    end
    for (int c = 0; c < 4; c++) begin
      wr(8'h14, {2'(c), 6'h25});
      `CHK("phase_algo", loop_cfg_pkg::phase_algo_t'(c), phase_algo)
      `CHK("phase_algo_valid", 1'(c != 3), phase_algo_valid)
      `CHK("beta_car", 6'h25, {beta_car_e, beta_car_c, beta_car_d})
    end
    // 0x7f tells a signed compare from an unsigned one
    wr(8'h15, 8'hf0);
    rd(8'h15, 8'hf0);
    for (int i = 0; i < 4; i++) begin
      carrier_lock_value = lv[i];
      tick(1);
      `CHK("carrier_locked", lk[i], carrier_locked)
    end
    // a reset in mid-run brings every register back
    rst = 1;
    tick(2);
    rst = 0;
    tick(2);
    `CHK("noise_avg_len", 19'h01000, noise_avg_len)
    `CHK("fd_threshold", 8'hc0, fd_threshold)
    `CHK("carrier_locked", 1'b1, carrier_locked)
    `CHK("setup", 8'h88, timing_lock_setup_value)
    for (int i = 0; i < 5; i++) rd(8'(8'h11 + i), rst_val[i]);
    finish_test();
  end
endmodule
